// ---- hw/wzt_pkg.sv ----
package wzt_pkg;
  localparam int W = 24;
  localparam longint CLK_HZ = 250000000;
  localparam longint AZS_SEC = 5;
  localparam longint AZS_CYC = AZS_SEC * CLK_HZ;
  localparam longint TRK_SEC = 1;
  localparam longint TRK_CYC = TRK_SEC * CLK_HZ;
  localparam longint BAND_PCT = 4;
  // Register offsets
  localparam logic [3:0] A_CTRL  = 4'h0;
  localparam logic [3:0] A_CMD   = 4'h1;
  localparam logic [3:0] A_MAX   = 4'h2;
  localparam logic [3:0] A_RSW   = 4'h3;
  localparam logic [3:0] A_TMAX  = 4'h4;
  localparam logic [3:0] A_STAT  = 4'h5;
  localparam logic [3:0] A_GROSS = 4'h6;
  localparam logic [3:0] A_NET   = 4'h7;
  localparam logic [3:0] A_TARE  = 4'h8;
  localparam logic [3:0] A_ZOFF  = 4'h9;
  // CTRL fields
  localparam int C_SH1 = 0;
  localparam int C_SH2 = 4;
  localparam int C_AZS = 8;
  localparam int C_TRK = 9;
  localparam int C_CMB = 10;
  localparam int C_MECH = 11;
  localparam int C_SUB = 12;
  localparam int C_GRS = 13;
  // CMD bits
  localparam int K_TARE = 0;
  localparam int K_ZERO = 1;
  localparam int K_PRT = 2;
  localparam int K_CLR = 3;
  localparam int K_TOFF = 4;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0331;
  localparam logic [W-1:0] MAX_RST = 24'h00EA60;
  localparam logic [W-1:0] RSW_RST = 24'h003A98;
  localparam logic [W-1:0] TMAX_RST = 24'h003A98;
  typedef enum logic [1:0] {SYM_NONE, SYM_G, SYM_N, SYM_T} wzt_sym_t;
  typedef struct packed {
    logic         vld;
    logic [W-1:0] val;
  } wzt_wt_t;
  typedef struct packed {
    logic [W-1:0] gross;
    logic [W-1:0] net;
    logic [W-1:0] tare;
    wzt_sym_t     g_sym;
    wzt_sym_t     n_sym;
    wzt_sym_t     t_sym;
    logic         n_calc;
    logic [1:0]   t_id;
  } wzt_prt_t;
endpackage

// ---- hw/wzt_core.sv ----
`timescale 1ns/1ns
module wzt_core #(
  parameter longint AZS_CYCLES = wzt_pkg::AZS_CYC,
  parameter longint TRK_CYCLES = wzt_pkg::TRK_CYC
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [23:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [23:0]                 reg_rdata,
  // Measurement front end
  input  wire wzt_pkg::wzt_wt_t       wt_in,
  input  wire logic                   stable_in,
  // Display
  output logic [23:0]                 disp_val,
  output logic                        disp_blank,
  output logic                        net_mark,
  output logic                        czero_mark,
  output logic                        over_mark,
  output logic [1:0]                  tare_id,
  // Printer
  output wzt_pkg::wzt_prt_t           prt_rec,
  output logic                        prt_vld
);
  localparam int W = wzt_pkg::W;
  typedef logic signed [W-1:0] wzt_sw_t;

  // Configuration and measurement state
  logic [15:0]       ctrl_r;
  wzt_sw_t           max_r;
  wzt_sw_t           rsw_r;
  wzt_sw_t           tmax_r;
  wzt_sw_t           wt_r;
  wzt_sw_t           zoff_r;
  wzt_sw_t           tare_r;
  logic              tact_r;
  logic [1:0]        tid_r;
  logic [31:0]       azs_cnt_r;
  logic [31:0]       trk_cnt_r;
  // Output side state
  wzt_sw_t           last_r;
  logic [23:0]       rdata_r;
  logic [23:0]       rd_mux;
  wzt_pkg::wzt_prt_t prt_r;
  logic              prt_vld_r;
  wzt_sw_t           disp_r;
  logic              blank_r;
  logic              netm_r;
  logic              czm_r;
  logic              over_r;

  // Rounding to a power-of-two interval, half up
  function automatic wzt_sw_t rnd(input wzt_sw_t x, input logic [3:0] sh);
    wzt_sw_t h;
    h = (sh == 4'h0) ? '0 : wzt_sw_t'(24'h1 << (sh - 4'h1));
    rnd = ((x + h) >>> sh) <<< sh;
  endfunction

  function automatic wzt_sw_t sabs(input wzt_sw_t x);
    sabs = x[W-1] ? -x : x;
  endfunction

  // Ranges and intervals
  wire logic [3:0]  sh1;
  wire logic [3:0]  sh2;
  wire logic [3:0]  sh;
  wire logic        cmb;
  wire logic        show_g;
  wire logic        hi_rng;
  wire wzt_sw_t     e_cur;
  wire wzt_sw_t     e1;
  wire wzt_sw_t     qtr;
  wire wzt_sw_t     half;
  wire wzt_sw_t     band;
  // Weights and shown value
  wire wzt_sw_t     gross;
  wire wzt_sw_t     net;
  wire wzt_sw_t     gross_rd;
  wire wzt_sw_t     net_rd;
  wire wzt_sw_t     tare_rd;
  wire wzt_sw_t     cand;
  wire logic        net_view;
  wire wzt_sw_t     shown_raw;
  wire wzt_sw_t     shown_rd;
  wire logic        cz;
  wire logic        over;
  // Command strobes
  wire logic        cmd_wr;
  wire logic        k_tare;
  wire logic        k_zero;
  wire logic        k_prt;
  wire logic        k_clr;
  wire logic        k_toff;
  // Zero, tare and print decisions
  wire logic        g_small;
  wire logic        do_zero;
  wire logic        tare_req;
  wire logic        tare_ok;
  wire logic        do_tare;
  wire logic        tare_bad;
  wire logic        azs_cond;
  wire logic        azs_fire;
  wire logic        trk_tick;
  wire logic        at_gz;
  wire logic        at_nz;
  wire logic        trk_on;
  wire logic        trk_g;
  wire logic        trk_n;
  wire wzt_sw_t     g_step;
  wire wzt_sw_t     n_step;
  wire logic        settled;
  wire logic        prt_ok;
  wire logic        do_prt;
  wire logic        prt_bad;
  wire logic [3:0]  stk_set;
  wire logic [3:0]  sticky;
  wire logic [23:0] stat;

  // Interval selection; range two above the switch threshold
  assign sh1 = ctrl_r[wzt_pkg::C_SH1 +: 4];
  assign sh2 = ctrl_r[wzt_pkg::C_SH2 +: 4];
  assign cmb = ctrl_r[wzt_pkg::C_CMB];
  assign show_g = ctrl_r[wzt_pkg::C_GRS];
  assign gross = wt_r - zoff_r;
  assign hi_rng = sabs(gross) > rsw_r;
  assign sh = hi_rng ? sh2 : sh1;
  assign e_cur = wzt_sw_t'(24'h1 << sh);
  assign e1 = wzt_sw_t'(24'h1 << sh1);
  assign qtr = wzt_sw_t'(e1 >>> 2);
  assign half = wzt_sw_t'(e1 >>> 1);

  // Band is centred on zero, so half of it lies on each side
  assign band = wzt_sw_t'((longint'(max_r) * wzt_pkg::BAND_PCT) / 200);

  // Rounded values; tare re-rounded to the range in use
  assign tare_rd = rnd(tare_r, sh);
  assign net = gross - tare_r;
  assign gross_rd = rnd(gross, sh);
  assign net_rd = gross_rd - tare_rd;
  assign cand = rnd(gross, sh);
  assign net_view = tact_r && !show_g;
  assign shown_raw = net_view ? net : gross;
  assign shown_rd = net_view ? net_rd : gross_rd;
  assign cz = sabs(shown_raw) <= qtr;
  assign over = gross > max_r;

  // Command decode
  assign cmd_wr = reg_wr && reg_addr == wzt_pkg::A_CMD;
  assign k_tare = cmd_wr && reg_wdata[wzt_pkg::K_TARE];
  assign k_zero = cmd_wr && reg_wdata[wzt_pkg::K_ZERO];
  assign k_prt = cmd_wr && reg_wdata[wzt_pkg::K_PRT];
  assign k_clr = cmd_wr && reg_wdata[wzt_pkg::K_CLR];
  assign k_toff = cmd_wr && reg_wdata[wzt_pkg::K_TOFF];

  // Combined key: one key zeroes near zero, tares elsewhere
  assign g_small = sabs(gross) <= qtr;
  assign do_zero = stable_in && (k_zero || (cmb && k_tare && g_small));
  assign tare_req = k_tare && !(cmb && g_small);
  assign tare_ok = stable_in && cand > 0 && cand <= tmax_r;
  assign do_tare = tare_req && tare_ok;
  assign tare_bad = tare_req && !tare_ok;

  // Auto zero: stable and below zero long enough
  assign azs_cond = ctrl_r[wzt_pkg::C_AZS] && stable_in && gross_rd < 0;
  assign azs_fire = azs_cond && azs_cnt_r >= 32'(AZS_CYCLES - 1);

  // Zero tracking: at gross zero (or net equal to gross zero), step capped
  assign trk_tick = trk_cnt_r >= 32'(TRK_CYCLES - 1);
  assign at_gz = gross_rd == 0;
  assign at_nz = tact_r && net_rd == 0 && sabs(net) <= band;
  assign trk_on = ctrl_r[wzt_pkg::C_TRK] && stable_in && trk_tick;
  assign trk_g = trk_on && at_gz && gross != 0;
  assign trk_n = trk_on && !at_gz && at_nz && net != 0;
  assign g_step = (sabs(gross) > half) ? (gross[W-1] ? -half : half) : gross;
  assign n_step = (sabs(net) > half) ? (net[W-1] ? -half : half) : net;

  // Print readiness: settled within one e of previous shown value
  assign settled = sabs(shown_rd - last_r) <= e_cur;
  assign prt_ok = stable_in && settled && !over;
  assign do_prt = k_prt && prt_ok;
  assign prt_bad = k_prt && !prt_ok;

  // Sticky events: print refused, track step, auto zero, tare refused
  assign stk_set = {prt_bad, trk_g | trk_n, azs_fire, tare_bad};
  assign stat = {13'h0000, tid_r, sticky, over, hi_rng, cz, tact_r, stable_in};

  // Read selection; unmapped offsets read as zero
  always_comb begin
    rd_mux = 24'h000000;
    if (reg_addr == wzt_pkg::A_CTRL) begin
      rd_mux = {8'h00, ctrl_r};
    end else if (reg_addr == wzt_pkg::A_MAX) begin
      rd_mux = max_r;
    end else if (reg_addr == wzt_pkg::A_RSW) begin
      rd_mux = rsw_r;
    end else if (reg_addr == wzt_pkg::A_TMAX) begin
      rd_mux = tmax_r;
    end else if (reg_addr == wzt_pkg::A_STAT) begin
      rd_mux = stat;
    end else if (reg_addr == wzt_pkg::A_GROSS) begin
      rd_mux = gross_rd;
    end else if (reg_addr == wzt_pkg::A_NET) begin
      rd_mux = net_rd;
    end else if (reg_addr == wzt_pkg::A_TARE) begin
      rd_mux = tare_rd;
    end else if (reg_addr == wzt_pkg::A_ZOFF) begin
      rd_mux = zoff_r;
    end
  end

  // Print record composition
  wzt_pkg::wzt_prt_t rec;
  always_comb begin
    rec = '0;
    rec.gross = gross_rd;
    rec.net = net_rd;
    rec.tare = tare_rd;
    rec.t_id = tid_r;
    rec.g_sym = wzt_pkg::SYM_G;
    rec.n_sym = wzt_pkg::SYM_N;
    rec.t_sym = tact_r ? wzt_pkg::SYM_T : wzt_pkg::SYM_NONE;
    rec.n_calc = tact_r;
    if (!tact_r) begin
      rec.net = gross_rd;
      rec.tare = '0;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r <= wzt_pkg::CTRL_RST;
      max_r <= wzt_pkg::MAX_RST;
      rsw_r <= wzt_pkg::RSW_RST;
      tmax_r <= wzt_pkg::TMAX_RST;
    end else if (reg_wr) begin
      if (reg_addr == wzt_pkg::A_CTRL) begin
        ctrl_r <= reg_wdata[15:0];
      end else if (reg_addr == wzt_pkg::A_MAX) begin
        max_r <= reg_wdata;
      end else if (reg_addr == wzt_pkg::A_RSW) begin
        rsw_r <= reg_wdata;
      end else if (reg_addr == wzt_pkg::A_TMAX) begin
        tmax_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= '0;
      wt_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 24'h000000;
      if (wt_in.vld) begin
        wt_r <= wt_in.val;
      end
    end
  end

  // Zero offset: manual zero, auto zero, tracking
  always_ff @(posedge core_clk) begin
    if (reset) begin
      zoff_r <= '0;
    end else if (do_zero) begin
      zoff_r <= wt_r;
    end else if (azs_fire) begin
      zoff_r <= wt_r;
    end else if (trk_g) begin
      zoff_r <= zoff_r + g_step;
    end
  end

  // Tare state; zero cancels tare, re-tare replaces value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tare_r <= '0;
      tact_r <= 1'b0;
      tid_r <= 2'h0;
    end else if (do_zero || k_toff) begin
      tare_r <= '0;
      tact_r <= 1'b0;
    end else if (do_tare) begin
      tare_r <= cand;
      tact_r <= 1'b1;
      tid_r <= tid_r + 2'h1;
    end else if (trk_n) begin
      tare_r <= tare_r + n_step;
    end
  end

  // Timers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      azs_cnt_r <= '0;
      trk_cnt_r <= '0;
    end else begin
      azs_cnt_r <= (azs_cond && !azs_fire) ? azs_cnt_r + 32'h1 : 32'h0;
      trk_cnt_r <= trk_tick ? 32'h0 : trk_cnt_r + 32'h1;
    end
  end

  // Sticky status, one flag per event; a new event wins over the clear
  for (genvar i = 0; i < 4; i++) begin : g_stk
    logic flag_r;
    always_ff @(posedge core_clk) begin
      if (reset) begin
        flag_r <= 1'b0;
      end else begin
        flag_r <= stk_set[i] | (flag_r & ~k_clr);
      end
    end
    assign sticky[i] = flag_r;
  end

  // Display and printer outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      disp_r <= '0;
      blank_r <= 1'b0;
      netm_r <= 1'b0;
      czm_r <= 1'b0;
      over_r <= 1'b0;
      last_r <= '0;
      prt_r <= '0;
      prt_vld_r <= 1'b0;
    end else begin
      disp_r <= shown_rd;
      blank_r <= over && ctrl_r[wzt_pkg::C_SUB];
      netm_r <= tact_r && (!show_g || cmb);
      czm_r <= cz;
      over_r <= over;
      last_r <= shown_rd;
      prt_vld_r <= do_prt;
      if (do_prt) begin
        prt_r <= rec;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign disp_val = disp_r;
  assign disp_blank = blank_r;
  assign net_mark = netm_r;
  assign czero_mark = czm_r;
  assign over_mark = over_r;
  assign tare_id = tid_r;
  assign prt_rec = prt_r;
  assign prt_vld = prt_vld_r;
endmodule // wzt_core

// ---- sim/wzt_fe.sv ----
`timescale 1ns/1ns
module wzt_fe (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Load on the pan
  input  wire logic [23:0]       load,
  input  wire logic              settle,
  // To the core
  output wzt_pkg::wzt_wt_t       wt_in,
  output logic                   stable_in
);
  // Load and verdict are both registered, so each arrives one cycle after its input
  always_ff @(posedge core_clk) begin
    wt_in     <= reset ? '0 : {1'b1, load};
    stable_in <= settle && !reset;
  end
endmodule  // wzt_fe

// ---- sim/wzt_core_sva.sv ----
`timescale 1ns/1ns
module wzt_core_sva #(
  parameter longint AZS_CYCLES = 20,
  parameter longint TRK_CYCLES = 8
) (
  // Clock, reset, register port
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic [3:0]        reg_addr,
  input wire logic [23:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [23:0]       reg_rdata,
  // Front end
  input wire wzt_pkg::wzt_wt_t  wt_in,
  input wire logic              stable_in,
  // Display and printer
  input wire logic [23:0]       disp_val,
  input wire logic              disp_blank,
  input wire logic              net_mark,
  input wire logic              czero_mark,
  input wire logic              over_mark,
  input wire logic [1:0]        tare_id,
  input wire wzt_pkg::wzt_prt_t prt_rec,
  input wire logic              prt_vld
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire cmd_unst = reg_wr && reg_addr == wzt_pkg::A_CMD && !stable_in;
  sequence s_tare_unst; cmd_unst && reg_wdata[wzt_pkg::K_TARE]; endsequence
  sequence s_prt_unst; cmd_unst && reg_wdata[wzt_pkg::K_PRT]; endsequence
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 24'h0)
    else $error("read data outside its slot");
  a_tare_unst: assert property (s_tare_unst |=> ##1 $stable(tare_id))
    else $error("tare taken while unstable");
  a_tare_step: assert property ($changed(tare_id) |->
    tare_id == $past(tare_id) + 2'h1 && $past(stable_in, 2))
    else $error("tare count step wrong");
  a_prt_unst: assert property (s_prt_unst |=> !prt_vld)
    else $error("print while unstable");
  a_prt_gsym: assert property (prt_vld |-> prt_rec.g_sym == wzt_pkg::SYM_G)
    else $error("gross symbol wrong");
  a_prt_calc: assert property (prt_vld && prt_rec.n_calc |->
    prt_rec.t_sym == wzt_pkg::SYM_T && prt_rec.n_sym == wzt_pkg::SYM_N)
    else $error("net or tare symbol wrong");
  a_prt_lone: assert property (prt_vld && !prt_rec.n_calc |->
    prt_rec.net == prt_rec.gross && prt_rec.tare == 24'h0)
    else $error("lone net record wrong");
  a_over_blank: assert property (disp_blank |-> over_mark)
    else $error("blank without overload");
  a_czero_val: assert property (czero_mark |-> disp_val == 24'h0)
    else $error("centre zero on nonzero value");
endmodule  // wzt_core_sva

bind wzt_core wzt_core_sva #(.AZS_CYCLES(AZS_CYCLES), .TRK_CYCLES(TRK_CYCLES)) u_wzt_core_sva (
  .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wt_in,
  .stable_in, .disp_val, .disp_blank, .net_mark, .czero_mark, .over_mark, .tare_id,
  .prt_rec, .prt_vld);

// ---- sim/test_weigh_zero_tare_control.sv ----
`timescale 1ns/1ns
module test_weigh_zero_tare_control;
  logic              core_clk  = 1'b0;
  logic              reset     = 1'b1;
  logic [3:0]        reg_addr  = 4'h0;
  logic [23:0]       reg_wdata = 24'h0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic              settle    = 1'b1;
  logic              rd_q1     = 1'b0;
  logic [23:0]       ld        = 24'h0;
  logic [23:0]       reg_rdata, disp_val;
  logic              disp_blank, net_mark, czero_mark, over_mark, prt_vld, stable_in;
  logic [1:0]        tare_id;
  wzt_pkg::wzt_wt_t  wt_in;
  wzt_pkg::wzt_prt_t prt_rec;
  wzt_pkg::wzt_prt_t pq[$];
  logic [23:0]       rq[$];
  int                error_cnt = 0;
  int                compares  = 0;
  int                seed      = 81709;
  wzt_fe u_wzt_fe (.core_clk, .reset, .load(ld), .settle, .wt_in, .stable_in);
  // Short counts keep auto-zero and tracking inside a brief run
  wzt_core #(.AZS_CYCLES(20), .TRK_CYCLES(8)) u_wzt_core (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wt_in,
    .stable_in, .disp_val, .disp_blank, .net_mark, .czero_mark, .over_mark, .tare_id,
    .prt_rec, .prt_vld);
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] d);
    wr(wzt_pkg::A_CMD, {16'h0, d});
    idle(3);
  endtask
  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic put(input logic [23:0] w);
    @(posedge core_clk);
    ld <= w;
    idle(4);
  endtask
  always @(posedge core_clk) begin
    rd_q1 <= reg_rd;
    if (rd_q1) chk(reg_rdata, rq.pop_front());
    if (prt_vld === 1'b1 && pq.size() > 0) chk(prt_rec, pq.pop_front());
    else if (prt_vld === 1'b1) chk(1'b1, 1'b0);
  end
  initial begin
    idle(5000);
    error_cnt++;
    stop_test();
  end
  initial begin
    logic [23:0] w;
    idle(3);
    reset <= 1'b0;
    rd(wzt_pkg::A_CTRL, 24'h331);
    rd(wzt_pkg::A_MAX, 24'hEA60);
    rd(wzt_pkg::A_TMAX, 24'h3A98);
    rd(4'hF, 24'h0);
    wr(wzt_pkg::A_CTRL, 24'h31);
    repeat (3) begin
      w = 24'($random(seed)) & 24'hFFE;
      put(w);
      @(negedge core_clk) chk(disp_val, w);
    end
    put(24'h65);
    rd(wzt_pkg::A_GROSS, 24'h66);
    put(24'h64);
    settle <= 1'b0;
    cmd(8'h01);
    rd(wzt_pkg::A_STAT, 24'h20);
    settle <= 1'b1;
    cmd(8'h08);
    cmd(8'h01);
    @(negedge core_clk) chk({net_mark, disp_val}, 25'h1000000);
    chk(tare_id, 2'h1);
    rd(wzt_pkg::A_STAT, 24'h207);
    rd(wzt_pkg::A_TARE, 24'h64);
    cmd(8'h01);
    rd(wzt_pkg::A_STAT, 24'h407);
    for (int i = 0; i < 2; i++) begin
      cmd(8'h08);
      put(i ? 24'h3B00 : 24'h0);
      cmd(8'h01);
      rd(wzt_pkg::A_STAT, i ? 24'h42B : 24'h423);
    end
    rd(wzt_pkg::A_TARE, 24'h68);
    put(24'hC8);
    wr(wzt_pkg::A_CTRL, 24'h2031);
    idle(3);
    @(negedge core_clk) chk({net_mark, disp_val}, 25'hC8);
    wr(wzt_pkg::A_CTRL, 24'h31);
    idle(3);
    @(negedge core_clk) chk({net_mark, disp_val}, 25'h1000064);
    pq.push_back('{24'hC8, 24'h64, 24'h64, wzt_pkg::SYM_G, wzt_pkg::SYM_N,
                   wzt_pkg::SYM_T, 1'b1, 2'h2});
    cmd(8'h04);
    settle <= 1'b0;
    cmd(8'h04);
    settle <= 1'b1;
    cmd(8'h10);
    pq.push_back('{24'hC8, 24'hC8, 24'h0, wzt_pkg::SYM_G, wzt_pkg::SYM_N,
                   wzt_pkg::SYM_NONE, 1'b0, 2'h2});
    cmd(8'h04);
    cmd(8'h08);
    wr(wzt_pkg::A_CTRL, 24'h1031);
    put(24'hEA70);
    @(negedge core_clk) chk({over_mark, disp_blank}, 2'h3);
    cmd(8'h04);
    rd(wzt_pkg::A_STAT, 24'h519);
    wr(wzt_pkg::A_CTRL, 24'h332);
    put(24'h32);
    cmd(8'h02);
    @(negedge core_clk) chk(czero_mark, 1'b1);
    rd(wzt_pkg::A_ZOFF, 24'h32);
    put(24'h2D);
    idle(30);
    rd(wzt_pkg::A_ZOFF, 24'h2D);
    put(24'h2E);
    idle(30);
    rd(wzt_pkg::A_ZOFF, 24'h2E);
    for (int i = 0; i < 8 && rq.size() + pq.size() > 0; i++) @(posedge core_clk);
    chk(32'(rq.size() + pq.size()), 32'h0);
    stop_test();
  end
endmodule  // test_weigh_zero_tare_control
